// ### hw/lvds_lane_pkg.sv
// Purpose: shared constants for the lvds serdes lane
// Assumes: one 25 MHz clock, classic wishbone register access
// Notes: byte offsets on a 32-bit data bus
package lvds_lane_pkg;
   localparam int WORD_W = 10;
   localparam int QUEUE_DEPTH = 8;
   localparam int DELAY_TAPS = 8;
   localparam int LOCK_WORDS = 4;
   localparam int ADR_W = 8;

   localparam logic [7:0] CTRL_ADR = 8'h00;
   localparam logic [7:0] CMD_ADR = 8'h04;
   localparam logic [7:0] STATUS_ADR = 8'h08;
   localparam logic [7:0] RXWORD_ADR = 8'h0C;
   localparam logic [7:0] TRAIN_ADR = 8'h10;

   localparam int CTRL_WIDTH_LSB = 0;
   localparam int CTRL_HALF_RATE = 4;
   localparam int CTRL_APA_ENABLE = 5;
   localparam int CTRL_QUEUE_ENABLE = 6;
   localparam int CTRL_TX_CLOCK_MODE = 7;
   localparam int CTRL_RX_BUFFER_ON = 8;
   localparam int CTRL_END_RESISTOR_ON = 9;
   localparam int CTRL_DRIVER_ON = 10;
   localparam int CTRL_DELAY_ADJUST_ON = 11;
   localparam logic [31:0] CTRL_MASK = 32'h0000_0FFF;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0508;

   localparam int CMD_DELAY_STEP = 0;
   localparam int CMD_DELAY_STEP_UP = 1;
   localparam int CMD_DELAY_CLEAR = 2;
   localparam int CMD_RX_LANE_CLEAR = 3;
   localparam int CMD_TX_LANE_CLEAR = 4;
   localparam int CMD_QUEUE_POP = 5;

   localparam int STAT_ALIGNED = 0;
   localparam int STAT_EMPTY = 1;
   localparam int STAT_OVERFLOW = 2;
   localparam int STAT_DELAY_LSB = 4;
   localparam int STAT_FILL_LSB = 8;

   localparam logic [9:0] TRAIN_RESET = 10'h0F0;
endpackage

// ### hw/lvds_serdes_lane.sv
// Purpose: lvds lane with deserializer, serializer, delay chain, phase alignment, rx queue
// Assumes: clk_i is the serial bit clock; two pad samples per cycle stand for both edges
// Notes: the word strobe is derived from a bit counter, not from a separate slow clock
//
// The placing of the registers and the Wishbone interface to the registers are this design's own decisions.
module lvds_serdes_lane #(
   parameter int WORD_W = lvds_lane_pkg::WORD_W,
   parameter int QUEUE_DEPTH = lvds_lane_pkg::QUEUE_DEPTH,
   parameter int DELAY_TAPS = lvds_lane_pkg::DELAY_TAPS,
   parameter int LOCK_WORDS = lvds_lane_pkg::LOCK_WORDS
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [lvds_lane_pkg::ADR_W-1:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic wb_we_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic [1:0] rx_serial_i,
   input wire logic queue_pop_i,
   input wire logic [WORD_W-1:0] tx_word_i,
   output logic [WORD_W-1:0] rx_word_o,
   output logic rx_word_valid_o,
   output logic queue_empty_flag_o,
   output logic phase_aligned_o,
   output logic bypass_input_o,
   output logic [1:0] tx_serial_o,
   output logic tx_word_take_o,
   output logic rx_buffer_on_o,
   output logic end_resistor_on_o,
   output logic driver_on_o
);
   localparam int DW = $clog2(DELAY_TAPS);
   localparam int QW = $clog2(QUEUE_DEPTH);
   localparam int CW = $clog2(WORD_W + 2);

   typedef enum logic [0:0] {APA_SEARCH, APA_LOCKED} apa_state_e;

   function automatic logic [CW-1:0] eff_width(input logic [3:0] w);
      if (w == 4'h0 || int'(w) > WORD_W) begin
         return CW'(WORD_W);
      end
      return CW'(w);
   endfunction

   function automatic logic [WORD_W-1:0] word_mask(input logic [CW-1:0] w);
      logic [WORD_W:0] m;
      m = ((WORD_W+1)'(1) << w) - (WORD_W+1)'(1);
      return m[WORD_W-1:0];
   endfunction

   function automatic logic [1:0] bits_per_cycle(input logic half);
      return half ? 2'h2 : 2'h1;
   endfunction

   logic [31:0] ctrl;
   logic [WORD_W-1:0] train;
   logic [DW-1:0] delay_cnt;
   logic overflow;
   logic [1:0] hist [DELAY_TAPS];
   logic [WORD_W-1:0] rx_sh;
   logic [CW-1:0] rx_cnt;
   logic [WORD_W-1:0] tx_sh;
   logic [CW-1:0] tx_cnt;
   logic [WORD_W-1:0] mem [QUEUE_DEPTH];
   logic [QW-1:0] wr_ptr;
   logic [QW-1:0] rd_ptr;
   logic [QW:0] fill;
   apa_state_e apa_state;
   logic [$clog2(LOCK_WORDS+1)-1:0] match_cnt;

   logic bus_go;
   logic bus_wr;
   logic cmd_wr;
   logic [CW-1:0] width;
   logic [1:0] bpc;
   logic half_rate;
   logic apa_on;
   logic queue_en;
   logic adj_on;
   logic step_req;
   logic step_up;
   logic delay_clr;
   logic rx_clear;
   logic tx_clear;
   logic pop_req;
   logic [1:0] rx_bits;
   logic [WORD_W-1:0] next_rx_sh;
   logic [CW:0] rx_sum;
   logic rx_done;
   logic [WORD_W-1:0] rx_word_now;
   logic push;
   logic pop;
   logic [CW:0] tx_sum;
   logic [WORD_W-1:0] tx_load;
   logic [31:0] next_dat;

   assign bus_go = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign bus_wr = bus_go && wb_we_i;
   assign cmd_wr = bus_wr && wb_adr_i == lvds_lane_pkg::CMD_ADR && wb_sel_i[0];
   assign width = eff_width(ctrl[lvds_lane_pkg::CTRL_WIDTH_LSB +: 4]);
   assign half_rate = ctrl[lvds_lane_pkg::CTRL_HALF_RATE];
   assign bpc = bits_per_cycle(half_rate);
   assign apa_on = ctrl[lvds_lane_pkg::CTRL_APA_ENABLE] && !half_rate;
   assign queue_en = ctrl[lvds_lane_pkg::CTRL_QUEUE_ENABLE];
   assign adj_on = ctrl[lvds_lane_pkg::CTRL_DELAY_ADJUST_ON];
   assign step_req = cmd_wr && wb_dat_i[lvds_lane_pkg::CMD_DELAY_STEP];
   assign step_up = wb_dat_i[lvds_lane_pkg::CMD_DELAY_STEP_UP];
   assign delay_clr = cmd_wr && wb_dat_i[lvds_lane_pkg::CMD_DELAY_CLEAR];
   assign rx_clear = cmd_wr && wb_dat_i[lvds_lane_pkg::CMD_RX_LANE_CLEAR];
   assign tx_clear = cmd_wr && wb_dat_i[lvds_lane_pkg::CMD_TX_LANE_CLEAR];
   assign pop_req = queue_pop_i || (cmd_wr && wb_dat_i[lvds_lane_pkg::CMD_QUEUE_POP]);

   // control register with byte enables
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl <= lvds_lane_pkg::CTRL_RESET;
         train <= lvds_lane_pkg::TRAIN_RESET;
      end else if (bus_wr) begin
         for (int i = 0; i < 4; i++) begin
            if (wb_sel_i[i] && wb_adr_i == lvds_lane_pkg::CTRL_ADR) begin
               ctrl[8*i +: 8] <= wb_dat_i[8*i +: 8] & lvds_lane_pkg::CTRL_MASK[8*i +: 8];
            end
         end
         if (wb_adr_i == lvds_lane_pkg::TRAIN_ADR && &wb_sel_i[1:0]) begin
            train <= wb_dat_i[WORD_W-1:0];
         end
      end
   end

   // pad controls
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rx_buffer_on_o <= 1'b0;
         end_resistor_on_o <= 1'b0;
         driver_on_o <= 1'b0;
      end else begin
         rx_buffer_on_o <= ctrl[lvds_lane_pkg::CTRL_RX_BUFFER_ON];
         end_resistor_on_o <= ctrl[lvds_lane_pkg::CTRL_END_RESISTOR_ON];
         driver_on_o <= ctrl[lvds_lane_pkg::CTRL_DRIVER_ON];
      end
   end

   // delay chain history; a disabled input buffer feeds zeros
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         hist[0] <= 2'h0;
      end else begin
         hist[0] <= ctrl[lvds_lane_pkg::CTRL_RX_BUFFER_ON] ? rx_serial_i : 2'h0;
      end
   end

   genvar g;
   generate
      for (g = 1; g < DELAY_TAPS; g++) begin : g_tap
         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               hist[g] <= 2'h0;
            end else begin
               hist[g] <= hist[g-1];
            end
         end
      end
   endgenerate

   assign rx_bits = hist[delay_cnt];

   // deserializer: first bit lands in bit 0
   always_comb begin
      next_rx_sh = rx_sh;
      if (int'(rx_cnt) < WORD_W) begin
         next_rx_sh[rx_cnt] = rx_bits[0];
      end
      if (half_rate && int'(rx_cnt) + 1 < WORD_W) begin
         next_rx_sh[rx_cnt + CW'(1)] = rx_bits[1];
      end
   end

   assign rx_sum = {1'b0, rx_cnt} + (CW+1)'(bpc);
   assign rx_done = rx_sum >= {1'b0, width};
   assign rx_word_now = next_rx_sh & word_mask(width);

   always_ff @(posedge clk_i) begin
      if (rst_i || rx_clear) begin
         rx_sh <= '0;
         rx_cnt <= '0;
      end else if (rx_done) begin
         rx_sh <= '0;
         rx_cnt <= '0;
      end else begin
         rx_sh <= next_rx_sh;
         rx_cnt <= rx_sum[CW-1:0];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         bypass_input_o <= 1'b0;
      end else begin
         bypass_input_o <= (width == CW'(1)) ? rx_bits[0] : 1'b0;
      end
   end

   // manual delay counter and phase alignment
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         delay_cnt <= '0;
         apa_state <= APA_SEARCH;
         match_cnt <= '0;
      end else if (delay_clr) begin
         if (apa_on) begin
            apa_state <= APA_SEARCH;
            match_cnt <= '0;
         end else begin
            delay_cnt <= '0;
         end
      end else if (apa_on) begin
         if (adj_on && rx_done) begin
            case (apa_state)
               APA_SEARCH: begin
                  if (rx_word_now == (train & word_mask(width))) begin
                     if (int'(match_cnt) + 1 >= LOCK_WORDS) begin
                        apa_state <= APA_LOCKED;
                     end
                     match_cnt <= match_cnt + 1'b1;
                  end else begin
                     match_cnt <= '0;
                     delay_cnt <= delay_cnt + 1'b1;
                  end
               end
               APA_LOCKED: begin
                  apa_state <= APA_LOCKED;
               end
               default: begin
                  apa_state <= APA_SEARCH;
               end
            endcase
         end
      end else begin
         apa_state <= APA_SEARCH;
         match_cnt <= '0;
         if (adj_on && step_req) begin
            delay_cnt <= step_up ? delay_cnt + 1'b1 : delay_cnt - 1'b1;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         phase_aligned_o <= 1'b0;
      end else begin
         phase_aligned_o <= apa_on && apa_state == APA_LOCKED;
      end
   end

   // receive queue, bypassed when disabled
   assign push = rx_done && queue_en && int'(fill) < QUEUE_DEPTH;
   assign pop = pop_req && queue_en && fill != '0;

   always_ff @(posedge clk_i) begin
      if (push) begin
         mem[wr_ptr] <= rx_word_now;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i || rx_clear || !queue_en) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         fill <= '0;
      end else begin
         if (push) begin
            wr_ptr <= (int'(wr_ptr) == QUEUE_DEPTH - 1) ? '0 : wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= (int'(rd_ptr) == QUEUE_DEPTH - 1) ? '0 : rd_ptr + 1'b1;
         end
         fill <= fill + (QW+1)'(push) - (QW+1)'(pop);
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         queue_empty_flag_o <= 1'b1;
      end else begin
         queue_empty_flag_o <= (rst_i || rx_clear || !queue_en) ? 1'b1 :
            (fill + (QW+1)'(push) - (QW+1)'(pop)) == '0;
      end
   end

   // overflow: set beats clear
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         overflow <= 1'b0;
      end else if (rx_done && queue_en && !push) begin
         overflow <= 1'b1;
      end else if (bus_wr && wb_adr_i == lvds_lane_pkg::STATUS_ADR && wb_sel_i[0] &&
         wb_dat_i[lvds_lane_pkg::STAT_OVERFLOW]) begin
         overflow <= 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i || rx_clear) begin
         rx_word_o <= rst_i ? '0 : rx_word_o;
         rx_word_valid_o <= 1'b0;
      end else if (queue_en) begin
         rx_word_valid_o <= pop;
         if (pop) begin
            rx_word_o <= mem[rd_ptr];
         end
      end else begin
         rx_word_valid_o <= rx_done;
         if (rx_done) begin
            rx_word_o <= rx_word_now;
         end
      end
   end

   // serializer, loads a new word at each boundary
   assign tx_sum = {1'b0, tx_cnt} + (CW+1)'(bpc);
   assign tx_load = ctrl[lvds_lane_pkg::CTRL_TX_CLOCK_MODE] ?
      word_mask(width - (width >> 1)) : (tx_word_i & word_mask(width));

   always_ff @(posedge clk_i) begin
      if (rst_i || tx_clear) begin
         tx_sh <= '0;
         tx_cnt <= '0;
         tx_serial_o <= 2'h0;
         tx_word_take_o <= 1'b0;
      end else begin
         tx_word_take_o <= tx_cnt == '0;
         if (tx_cnt == '0) begin
            tx_serial_o <= {half_rate & tx_load[1], tx_load[0]};
            tx_sh <= tx_load >> bpc;
         end else begin
            tx_serial_o <= {half_rate & tx_sh[1], tx_sh[0]};
            tx_sh <= tx_sh >> bpc;
         end
         tx_cnt <= (tx_sum >= {1'b0, width}) ? '0 : tx_sum[CW-1:0];
      end
   end

   // wishbone slave: one wait state, unmapped reads return zero
   always_comb begin
      next_dat = 32'h0000_0000;
      case (wb_adr_i)
         lvds_lane_pkg::CTRL_ADR: next_dat = ctrl;
         lvds_lane_pkg::STATUS_ADR: begin
            next_dat[lvds_lane_pkg::STAT_ALIGNED] = phase_aligned_o;
            next_dat[lvds_lane_pkg::STAT_EMPTY] = queue_empty_flag_o;
            next_dat[lvds_lane_pkg::STAT_OVERFLOW] = overflow;
            next_dat[lvds_lane_pkg::STAT_DELAY_LSB +: DW] = delay_cnt;
            next_dat[lvds_lane_pkg::STAT_FILL_LSB +: QW+1] = fill;
         end
         lvds_lane_pkg::RXWORD_ADR: next_dat[WORD_W-1:0] = rx_word_o;
         lvds_lane_pkg::TRAIN_ADR: next_dat[WORD_W-1:0] = train;
         default: next_dat = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= bus_go;
         wb_dat_o <= bus_go ? next_dat : 32'h0000_0000;
      end
   end
endmodule // lvds_serdes_lane

// ### verif/lane_checker.sv
// Purpose: port checks for the lvds lane
// Assumes: one clock, sync active high reset
// Notes: bound to the top module
module lane_checker #(
   parameter int WORD_W = 10
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   input wire logic [31:0] wb_dat_o,
   input wire logic queue_pop_i,
   input wire logic [WORD_W-1:0] rx_word_o,
   input wire logic rx_word_valid_o,
   input wire logic queue_empty_flag_o,
   input wire logic phase_aligned_o,
   input wire logic [1:0] tx_serial_o,
   input wire logic tx_word_take_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence s_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence s_quiet;
      !wb_ack_o [*2];
   endsequence
   a_bus_answer: assert property (s_req |=> wb_ack_o)
      else $error("no ack one cycle after request");
   a_ack_gap: assert property (wb_ack_o |=> s_quiet)
      else $error("ack longer than one cycle");
   a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
      else $error("ack without request");
   a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
      else $error("read data outside ack");
   a_word_hold: assert property (!rx_word_valid_o |-> $stable(rx_word_o))
      else $error("rx word changed without valid");
   a_pop_delivers: assert property (
      queue_pop_i && !queue_empty_flag_o |=> rx_word_valid_o) else $error("pop gave no word");
   a_reset_rx: assert property (
      disable iff (1'b0) rst_i |=> queue_empty_flag_o &&
      !phase_aligned_o && !rx_word_valid_o) else $error("receive state not cleared by reset");
   a_reset_tx: assert property (disable iff (1'b0) rst_i |=>
      tx_serial_o == 2'b00 && !tx_word_take_o) else $error("serializer not cleared by reset");
endmodule // lane_checker

bind lvds_serdes_lane lane_checker #(.WORD_W(WORD_W)) u_lane_checker (
   .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .queue_pop_i(queue_pop_i),
   .rx_word_o(rx_word_o), .rx_word_valid_o(rx_word_valid_o),
   .queue_empty_flag_o(queue_empty_flag_o), .phase_aligned_o(phase_aligned_o),
   .tx_serial_o(tx_serial_o), .tx_word_take_o(tx_word_take_o)
);

// ### verif/lvds_far_end.sv
// Purpose: far lvds end: sends a repeating word, captures the lane output
// Assumes: full rate, one bit per clock, lsb first
// Notes: bit1 carries no data and toggles against bit0
module lvds_far_end #(
   parameter int W = 8
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [W-1:0] word_i,
   input wire logic [1:0] tx_serial_i,
   output logic [1:0] rx_serial_o,
   output logic [W-1:0] seen_o
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt <= 0;
         rx_serial_o <= 2'b10;
      end else begin
         cnt <= (cnt == W - 1) ? 0 : cnt + 1;
         rx_serial_o <= {~word_i[cnt], word_i[cnt]};
      end
   end
   always_ff @(posedge clk_i) begin
      seen_o <= {tx_serial_i[0], seen_o[W-1:1]};
   end
endmodule // lvds_far_end

// ### verif/tb.sv
// Purpose: self-checking bench for the lvds lane
// Assumes: width 8, training word 0xF0
// Notes: registers reached over classic wishbone
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [7:0] wb_adr_i = 8'h00;
   logic [31:0] wb_dat_i = 32'h0;
   logic [3:0] wb_sel_i = 4'h0;
   logic wb_we_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, queue_pop_i = 1'b0;
   logic [9:0] tx_word_i = 10'h000;
   logic [9:0] rx_word_o;
   logic [31:0] wb_dat_o, rd;
   logic [1:0] rx_serial_i, tx_serial_o;
   logic [7:0] seen;
   logic wb_ack_o, rx_word_valid_o, queue_empty_flag_o, phase_aligned_o, bypass_input_o;
   logic tx_word_take_o, rx_buffer_on_o, end_resistor_on_o, driver_on_o;
   int fails = 0;
   int tests_run = 0;

   lvds_serdes_lane dut (
      .clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
      .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rx_serial_i(rx_serial_i),
      .queue_pop_i(queue_pop_i), .tx_word_i(tx_word_i), .rx_word_o(rx_word_o),
      .rx_word_valid_o(rx_word_valid_o), .queue_empty_flag_o(queue_empty_flag_o),
      .phase_aligned_o(phase_aligned_o), .bypass_input_o(bypass_input_o),
      .tx_serial_o(tx_serial_o), .tx_word_take_o(tx_word_take_o),
      .rx_buffer_on_o(rx_buffer_on_o), .end_resistor_on_o(end_resistor_on_o),
      .driver_on_o(driver_on_o)
   );
   lvds_far_end #(.W(8)) far (
      .clk_i(clk_i), .rst_i(rst_i), .word_i(8'hF0), .tx_serial_i(tx_serial_o),
      .rx_serial_o(rx_serial_i), .seen_o(seen)
   );

   initial begin
      forever #20 clk_i = ~clk_i;
   end

   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic wb(input logic [7:0] a, input logic we, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      wb_adr_i <= a;
      wb_we_i <= we;
      wb_dat_i <= d;
      wb_sel_i <= 4'hF;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 50);
      if (n >= 50) fails++;
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
   endtask

   task automatic tx_check(input logic [7:0] exp);
      int n;
      n = 0;
      do begin
         @(negedge clk_i);
         n++;
      end while (tx_word_take_o !== 1'b1 && n < 100);
      if (n >= 100) fails++;
      repeat (8) @(posedge clk_i);
      @(negedge clk_i);
      check("tx_serial", {24'h0, exp}, {24'h0, seen});
   endtask

   task automatic finish_test();
      if (fails == 0 && tests_run > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge clk_i);
      fails++;
      finish_test();
   end

   initial begin
      int n;
      logic [2:0] dly;
      logic [7:0] w;
      logic [2:0] h;
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(8'h00, 0, 0);
      check("ctrl", 32'h0000_0508, rd);
      wb(8'h08, 0, 0);
      check("status", 32'h0000_0002, rd);
      wb(8'h10, 0, 0);
      check("train", 32'h0000_00F0, rd);
      wb(8'h40, 0, 0);
      check("unmapped", 32'h0, rd);
      check("pads", 32'h5, {driver_on_o, end_resistor_on_o, rx_buffer_on_o});
      wb(8'h00, 1, 32'h0000_0208);
      @(negedge clk_i);
      check("pads", 32'h2, {driver_on_o, end_resistor_on_o, rx_buffer_on_o});
      wb(8'h00, 1, 32'h0000_0D08);
      wb(8'h04, 1, 32'h3);
      wb(8'h04, 1, 32'h3);
      wb(8'h04, 1, 32'h1);
      wb(8'h08, 0, 0);
      check("delay", 32'h1, {29'h0, rd[6:4]});
      wb(8'h04, 1, 32'h4);
      wb(8'h08, 0, 0);
      check("delay", 32'h0, {29'h0, rd[6:4]});
      wb(8'h00, 1, 32'h0000_0F28);
      n = 0;
      while (phase_aligned_o !== 1'b1 && n < 3000) begin
         @(negedge clk_i);
         n++;
      end
      check("aligned", 1, {31'h0, phase_aligned_o});
      check("term", 1, {31'h0, end_resistor_on_o});
      do begin
         @(negedge clk_i);
         n++;
      end while (rx_word_valid_o !== 1'b1 && n < 3100);
      if (n >= 3100) fails++;
      check("rx_word", 32'h0F0, {22'h0, rx_word_o});
      wb(8'h08, 0, 0);
      dly = rd[6:4];
      wb(8'h04, 1, 32'h3);
      wb(8'h08, 0, 0);
      check("apa_step", {29'h0, dly}, {29'h0, rd[6:4]});
      wb(8'h00, 1, 32'h0000_0F68);
      repeat (120) @(posedge clk_i);
      wb(8'h08, 0, 0);
      check("queue", 32'h0000_0805, rd & 32'h0000_0F07);
      queue_pop_i <= 1'b1;
      @(posedge clk_i);
      queue_pop_i <= 1'b0;
      @(negedge clk_i);
      check("pop", 32'h0000_04F0, {21'h0, rx_word_valid_o, rx_word_o});
      wb(8'h04, 1, 32'h20);
      wb(8'h0C, 0, 0);
      check("rx_word_reg", 32'h0000_00F0, rd);
      wb(8'h04, 1, 32'h8);
      @(negedge clk_i);
      check("cleared", 1, {31'h0, queue_empty_flag_o});
      @(posedge clk_i);
      queue_pop_i <= 1'b1;
      @(posedge clk_i);
      queue_pop_i <= 1'b0;
      @(negedge clk_i);
      check("pop_empty", 0, {31'h0, rx_word_valid_o});
      wb(8'h08, 1, 32'h4);
      wb(8'h08, 0, 0);
      check("overflow_clr", 32'h0, {31'h0, rd[2]});
      wb(8'h00, 1, 32'h0000_0D38);
      wb(8'h04, 1, 32'h4);
      repeat (300) @(posedge clk_i);
      @(negedge clk_i);
      check("half_lock", 0, {31'h0, phase_aligned_o});
      @(posedge clk_i);
      tx_word_i <= 10'h0A5;
      wb(8'h00, 1, 32'h0000_0508);
      tx_check(8'hA5);
      wb(8'h00, 1, 32'h0000_0518);
      n = 0;
      do begin
         @(negedge clk_i);
         n++;
      end while (tx_word_take_o !== 1'b1 && n < 100);
      if (n >= 100) fails++;
      for (int i = 0; i < 4; i++) begin
         w[2*i +: 2] = tx_serial_o;
         @(negedge clk_i);
      end
      check("tx_half", 32'h0000_00A5, {24'h0, w});
      wb(8'h00, 1, 32'h0000_0588);
      tx_check(8'h0F);
      wb(8'h04, 1, 32'h10);
      @(negedge clk_i);
      check("tx_restart", 32'h5, {29'h0, tx_word_take_o, tx_serial_o});
      wb(8'h00, 1, 32'h0000_0501);
      h = 3'h0;
      for (int i = 0; i < 10; i++) begin
         @(negedge clk_i);
         h = {h[1:0], rx_serial_i[0]};
         if (i > 1) begin
            check("bypass", {31'h0, h[2]}, {31'h0, bypass_input_o});
         end
      end
      wb(8'h10, 1, 32'h0000_03C5);
      wb(8'h10, 0, 0);
      check("train_wr", 32'h0000_03C5, rd);
      finish_test();
   end
endmodule // tb
